// file: hdl/nsfm_fault_mgr.sv
`timescale 1ns/1ps
`default_nettype none
`include "nsfm_cfg.svh"
module nsfm_fault_mgr #(
   parameter int NCH = 16,
   parameter int BLANK_STEP_CYC = 25,
   parameter int OPEN_DEG_CYC = 25
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bat_uv_in,
   input wire logic ldo_uv_in,
   input wire logic sup_low_in,
   input wire logic sup_uv_fall_in,
   input wire logic sup_uv_rise_in,
   input wire logic ref_fault_in,
   input wire logic pre_thermal_in,
   input wire logic tsd1_in,
   input wire logic tsd2_in,
   input wire logic [NCH-1:0] chan_open_in,
   input wire logic [NCH-1:0] pwm_on,
   output logic err_n_o,
   output logic err_n_oe,
   output logic [NCH-1:0] channel_output,
   output logic [5:0] low_supply_threshold,
   output logic open_diag_en,
   output logic sls_diag_en,
   output logic regulator_off
);
   localparam int PULSE_CYC = `NSFM_PULSE_US * `NSFM_CLK_MHZ;
   localparam int NS = NCH + 9; // Synchronised inputs

   // Two-stage synchronisers for every comparator input; pwm_on and the bus are not synchronised
   logic [NS-1:0] sync_in; // Raw pins, channel opens on top
   logic [NS-1:0] sync2_reg; // Second stages, the only ones logic reads
   logic bat_uv_s, ldo_uv_s, sup_low_s, uvf_s, uvr_s;
   logic ref_s, pret_s, tsd1_s, tsd2_s;
   logic [NCH-1:0] open_s;

   assign sync_in = {chan_open_in, tsd2_in, tsd1_in, pre_thermal_in, ref_fault_in,
      sup_uv_rise_in, sup_uv_fall_in, sup_low_in, ldo_uv_in, bat_uv_in};

   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         logic s1_reg, s2_reg; // First and second stage of this pin
         // First stage feeds only the second
         always_ff @(posedge ref_clk) begin
            if (srst) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
            end else begin
               s1_reg <= sync_in[gi];
               s2_reg <= s1_reg;
            end
         end
         assign sync2_reg[gi] = s2_reg;
      end
   endgenerate

   assign {tsd2_s, tsd1_s, pret_s, ref_s, uvr_s, uvf_s, sup_low_s, ldo_uv_s,
      bat_uv_s} = sync2_reg[8:0];
   assign open_s = sync2_reg[NS-1:9];

   // Operating state
   nsfm_pkg::nsfm_state_t state_reg, state_next;
   logic supply_lost;
   assign supply_lost = bat_uv_s || ldo_uv_s;

   // State transitions
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         nsfm_pkg::NSFM_ST_POR: begin
            // Leave reset only once supplies and die are fine
            if (!supply_lost && !tsd2_s) begin
               state_next = nsfm_pkg::NSFM_ST_INIT;
            end
         end
         nsfm_pkg::NSFM_ST_SHUT: begin
            if (supply_lost || !tsd2_s) begin
               state_next = nsfm_pkg::NSFM_ST_POR;
            end
         end
         nsfm_pkg::NSFM_ST_INIT,
         nsfm_pkg::NSFM_ST_NORMAL: begin
            if (supply_lost) begin
               state_next = nsfm_pkg::NSFM_ST_POR;
            end else if (tsd2_s) begin
               state_next = nsfm_pkg::NSFM_ST_SHUT;
            end else begin
               state_next = nsfm_pkg::NSFM_ST_NORMAL;
            end
         end
         default: begin
            state_next = nsfm_pkg::NSFM_ST_POR;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= nsfm_pkg::NSFM_ST_POR;
      end else begin
         state_reg <= state_next;
      end
   end

   // Soft reset: registers held at defaults while in reset state
   logic soft_rst;
   assign soft_rst = (state_reg == nsfm_pkg::NSFM_ST_POR);

   // Bus strobes
   logic wr_acc, setup;
   assign wr_acc = psel && penable && pwrite;
   assign setup = psel && !penable;

   // Merge byte lanes of a write
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] m;
      m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
      merge = (old & ~m) | (wd & m);
   endfunction

   // Software registers and latched flags
   logic clr_por_reg, clr_por_next; // Self-clearing command bits
   logic clr_flt_reg, clr_flt_next;
   logic [5:0] th_reg, th_next;
   logic [3:0] blank_reg, blank_next;
   logic [NCH-1:0] chen_reg, chen_next;
   logic f_por_reg, f_por_next, f_err_reg, f_err_next;
   logic f_low_reg, f_low_next, f_uv_reg, f_uv_next;
   logic f_ref_reg, f_ref_next, f_pret_reg, f_pret_next;
   logic f_tsd_reg, f_tsd_next, f_out_reg, f_out_next;
   logic [NCH-1:0] f_open_reg, f_open_next;
   logic uv_act_reg, uv_act_next; // Undervoltage with hysteresis
   logic low_d_reg, pret_d_reg; // Edge history for pulsed events
   logic [NCH-1:0] open_evt;
   logic [31:0] ctrl_w, tmp;
   logic [5:0] th_w;

   // Next values of registers and flags
   always_comb begin
      clr_por_next = 1'b0;
      clr_flt_next = 1'b0;
      th_next = th_reg;
      blank_next = blank_reg;
      chen_next = chen_reg;
      ctrl_w = merge(32'h0000_0000, pwdata, pstrb);
      th_w = ctrl_w[`NSFM_CTRL_TH_LSB +: 6];
      tmp = merge(32'(chen_reg), pwdata, pstrb);
      if (wr_acc && paddr == `NSFM_OFF_CTRL) begin
         clr_por_next = ctrl_w[`NSFM_CTRL_POWER_ON_CLEAR_BIT];
         clr_flt_next = ctrl_w[`NSFM_CTRL_CLRFLT];
         if (pstrb[1]) begin
            // Out-of-range codes saturate to the nearest limit
            if (th_w < `NSFM_TH_MIN) begin
               th_next = `NSFM_TH_MIN;
            end else if (th_w > `NSFM_TH_MAX) begin
               th_next = `NSFM_TH_MAX;
            end else begin
               th_next = th_w;
            end
         end
      end
      if (wr_acc && paddr == `NSFM_OFF_BLANK && pstrb[0]) begin
         blank_next = pwdata[3:0];
      end
      if (wr_acc && paddr == `NSFM_OFF_CHEN) begin
         chen_next = tmp[NCH-1:0];
      end
      // Undervoltage active from falling until rising threshold
      uv_act_next = uv_act_reg;
      if (uvf_s) begin
         uv_act_next = 1'b1;
      end else if (uvr_s) begin
         uv_act_next = 1'b0;
      end
      // Clears first, sets after: an event in the clear cycle wins
      f_por_next = f_por_reg && !clr_por_reg;
      f_low_next = f_low_reg && !clr_flt_reg;
      f_uv_next = f_uv_reg && !clr_flt_reg;
      f_ref_next = f_ref_reg && !clr_flt_reg;
      f_pret_next = f_pret_reg && !clr_flt_reg;
      f_tsd_next = f_tsd_reg && !clr_flt_reg;
      f_out_next = f_out_reg && !clr_flt_reg;
      f_open_next = clr_flt_reg ? '0 : f_open_reg;
      if (state_reg == nsfm_pkg::NSFM_ST_INIT ||
          state_reg == nsfm_pkg::NSFM_ST_SHUT) begin
         f_por_next = 1'b1;
      end
      if (sup_low_s) begin
         f_low_next = 1'b1;
      end
      if (uvf_s) begin
         f_uv_next = 1'b1;
      end
      if (ref_s) begin
         f_ref_next = 1'b1;
      end
      if (pret_s) begin
         f_pret_next = 1'b1;
      end
      if (tsd1_s) begin
         f_tsd_next = 1'b1;
      end
      // Open events latch the channel flags and the output flag; channels stay enabled
      f_open_next = f_open_next | open_evt;
      if (|open_evt) begin
         f_out_next = 1'b1;
      end
      // Global error summarises every latched flag
      f_err_next = f_por_next || f_low_next || f_uv_next || f_ref_next ||
         f_pret_next || f_tsd_next || f_out_next;
   end

   // Register update; reset state restores every default
   always_ff @(posedge ref_clk) begin
      if (srst || soft_rst) begin
         clr_por_reg <= 1'b0;
         clr_flt_reg <= 1'b0;
         th_reg <= `NSFM_TH_RST;
         blank_reg <= `NSFM_BLANK_RST;
         chen_reg <= NCH'(`NSFM_CHEN_RST);
         f_por_reg <= 1'b0;
         f_err_reg <= 1'b0;
         f_low_reg <= 1'b0;
         f_uv_reg <= 1'b0;
         f_ref_reg <= 1'b0;
         f_pret_reg <= 1'b0;
         f_tsd_reg <= 1'b0;
         f_out_reg <= 1'b0;
         f_open_reg <= '0;
         uv_act_reg <= 1'b0;
         low_d_reg <= 1'b0;
         pret_d_reg <= 1'b0;
      end else begin
         clr_por_reg <= clr_por_next;
         clr_flt_reg <= clr_flt_next;
         th_reg <= th_next;
         blank_reg <= blank_next;
         chen_reg <= chen_next;
         f_por_reg <= f_por_next;
         f_err_reg <= f_err_next;
         f_low_reg <= f_low_next;
         f_uv_reg <= f_uv_next;
         f_ref_reg <= f_ref_next;
         f_pret_reg <= f_pret_next;
         f_tsd_reg <= f_tsd_next;
         f_out_reg <= f_out_next;
         f_open_reg <= f_open_next;
         uv_act_reg <= uv_act_next;
         low_d_reg <= sup_low_s;
         pret_d_reg <= pret_s;
      end
   end

   // Per-channel open detectors
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_open
         nsfm_open_det #(
            .BLANK_STEP_CYC(BLANK_STEP_CYC),
            .DEG_CYC(OPEN_DEG_CYC)
         ) u_det (
            .ref_clk(ref_clk),
            .srst(srst),
            .diag_en(open_diag_en && channel_output[gi]),
            .pwm_on(pwm_on[gi]),
            .open_cmp(open_s[gi]),
            .blank_code(blank_reg),
            .open_evt(open_evt[gi])
         );
      end
   endgenerate

   // Pulse engine: pending count, fixed width, two idle cycles between
   logic [10:0] pcnt_reg, pcnt_next;
   logic [2:0] pend_reg, pend_next;
   logic gap_reg, gap_next;
   logic [1:0] nev;
   always_comb begin
      nev = 2'(sup_low_s && !low_d_reg) + 2'(pret_s && !pret_d_reg) +
         2'(|open_evt);
      pend_next = pend_reg;
      if (pend_reg <= 3'(7 - int'(nev))) begin
         pend_next = pend_reg + 3'(nev);
      end
      pcnt_next = pcnt_reg;
      gap_next = 1'b0;
      if (pcnt_reg != 11'h000) begin
         pcnt_next = pcnt_reg - 11'h001;
         gap_next = (pcnt_reg == 11'h001); // Keeps pulses distinct
      end else if (!gap_reg && pend_reg != 3'h0) begin
         pcnt_next = 11'(PULSE_CYC);
         pend_next = pend_next - 3'h1;
      end
   end

   // Pulse engine registers
   always_ff @(posedge ref_clk) begin
      if (srst || soft_rst) begin
         pcnt_reg <= 11'h000;
         pend_reg <= 3'h0;
         gap_reg <= 1'b0;
      end else begin
         pcnt_reg <= pcnt_next;
         pend_reg <= pend_next;
         gap_reg <= gap_next;
      end
   end

   // Pin and gating outputs, registered
   logic sink_next, sink_reg, shut;
   logic [NCH-1:0] outen_next;
   assign shut = (state_reg == nsfm_pkg::NSFM_ST_SHUT);
   always_comb begin
      // Live conditions hold the pin; recovery releases it
      sink_next = uv_act_next || ref_s || tsd1_s || tsd2_s ||
         (pcnt_next != 11'h000);
      outen_next = chen_reg;
      if (uv_act_next || tsd1_s || state_next != nsfm_pkg::NSFM_ST_NORMAL) begin
         outen_next = '0;
      end
   end

   // Output registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sink_reg <= 1'b0;
         channel_output <= '0;
         open_diag_en <= 1'b0;
         regulator_off <= 1'b0;
      end else begin
         sink_reg <= sink_next;
         channel_output <= outen_next;
         open_diag_en <= !sup_low_s;
         regulator_off <= (state_next == nsfm_pkg::NSFM_ST_SHUT);
      end
   end
   assign sls_diag_en = open_diag_en;
   assign err_n_o = 1'b0; // Open drain only ever sinks
   assign err_n_oe = sink_reg || shut;
   assign low_supply_threshold = th_reg;

   // Bus read path: data captured in setup, shown in access
   logic [31:0] rd_reg, rd_next;
   logic serr_reg, serr_next;
   always_comb begin
      rd_next = rd_reg;
      serr_next = serr_reg;
      if (setup) begin
         serr_next = 1'b0;
         case (paddr)
            `NSFM_OFF_CTRL: rd_next = {18'h0, th_reg, 6'h0, clr_flt_reg,
               clr_por_reg};
            `NSFM_OFF_BLANK: rd_next = {28'h0, blank_reg};
            `NSFM_OFF_FLAGS: rd_next = {24'h0, f_out_reg, f_tsd_reg,
               f_pret_reg, f_ref_reg, f_uv_reg, f_low_reg, f_err_reg, f_por_reg};
            `NSFM_OFF_OPEN: rd_next = 32'(f_open_reg);
            `NSFM_OFF_CHEN: rd_next = 32'(chen_reg);
            `NSFM_OFF_STAT: rd_next = {18'h0, tsd2_s, tsd1_s, pret_s, ref_s,
               uv_act_reg, sup_low_s, ldo_uv_s, bat_uv_s, 2'h0, state_reg};
            default: begin
               rd_next = 32'h0000_0000;
               serr_next = 1'b1; // Unmapped address
            end
         endcase
      end
   end

   // Read registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_reg <= 32'h0000_0000;
         serr_reg <= 1'b0;
      end else begin
         rd_reg <= rd_next;
         serr_reg <= serr_next;
      end
   end
   assign prdata = rd_reg;
   assign pready = 1'b1;
   assign pslverr = psel && penable && serr_reg;

   // Checks
   int unsigned plen_reg;
   always_ff @(posedge ref_clk) begin
      if (srst || pcnt_reg == 11'h000) begin
         plen_reg <= 0;
      end else begin
         plen_reg <= plen_reg + 1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   chk_por_recover: assert property (
      !srst && state_reg == nsfm_pkg::NSFM_ST_POR && !supply_lost && !tsd2_s |=>
      state_reg == nsfm_pkg::NSFM_ST_INIT ##1 f_por_reg && f_err_reg)
      else $error("no init with power-on flag after recovery");
   chk_por_clear: assert property (
      clr_por_reg && state_reg == nsfm_pkg::NSFM_ST_NORMAL |=>
      !f_por_reg ##1 !clr_por_reg)
      else $error("power-on flag not cleared");
   chk_pulse_len: assert property (
      pcnt_reg == 11'h001 |-> plen_reg == PULSE_CYC - 1)
      else $error("pulse width wrong");
   chk_low_flag: assert property (
      sup_low_s && !soft_rst |=> f_low_reg && f_err_reg)
      else $error("low-supply flag not set");
   chk_diag_gate: assert property (
      sup_low_s |=> !open_diag_en && !sls_diag_en)
      else $error("diagnostics not disabled");
   chk_th_range: assert property (
      th_reg >= `NSFM_TH_MIN && th_reg <= `NSFM_TH_MAX)
      else $error("threshold out of range");
   chk_uv_sink: assert property (
      uvf_s |=> err_n_oe && uv_act_reg)
      else $error("undervoltage sink missing");
   chk_uv_outs: assert property (
      uv_act_reg |-> channel_output == '0)
      else $error("outputs on during undervoltage");
   chk_ref_sink: assert property (
      ref_s |=> err_n_oe ##1 f_ref_reg || soft_rst)
      else $error("reference fault not reported");
   chk_tsd_off: assert property (
      tsd1_s |=> channel_output == '0 && err_n_oe)
      else $error("outputs on in thermal shutdown");
   chk_shut_reg: assert property (
      state_reg == nsfm_pkg::NSFM_ST_SHUT |-> regulator_off && err_n_oe)
      else $error("regulator on in shutdown");
   chk_open_flag: assert property (
      |open_evt && !soft_rst |=> f_out_reg && f_err_reg ##[1:2] err_n_oe)
      else $error("open event not reported");
endmodule // nsfm_fault_mgr
`default_nettype wire

// file: hdl/nsfm_open_det.sv
`timescale 1ns/1ps
`default_nettype none
// One channel of open-circuit detection: blanking then deglitch
module nsfm_open_det #(
   parameter int BLANK_STEP_CYC = 25,
   parameter int DEG_CYC = 25
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic diag_en,
   input wire logic pwm_on,
   input wire logic open_cmp,
   input wire logic [3:0] blank_code,
   output logic open_evt
);
   logic [15:0] on_cnt_reg, on_cnt_next; // Cycles into on phase
   logic [15:0] deg_cnt_reg, deg_cnt_next; // Consecutive open cycles
   logic [15:0] blank_lim;
   logic armed;

   // Blanking length from the 4-bit field
   assign blank_lim = 16'(int'(blank_code) * BLANK_STEP_CYC);
   // Only evaluate past blanking inside the on phase
   assign armed = pwm_on && diag_en && (on_cnt_reg >= blank_lim);

   // Next counts
   always_comb begin
      on_cnt_next = on_cnt_reg;
      deg_cnt_next = deg_cnt_reg;
      if (!pwm_on) begin
         on_cnt_next = 16'h0000;
      end else if (on_cnt_reg != 16'hFFFF) begin
         on_cnt_next = on_cnt_reg + 16'h0001;
      end
      // Short on-times never reach the deglitch end
      if (!armed || !open_cmp) begin
         deg_cnt_next = 16'h0000;
      end else if (deg_cnt_reg != 16'(DEG_CYC)) begin
         deg_cnt_next = deg_cnt_reg + 16'h0001;
      end
   end

   // Registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         on_cnt_reg <= 16'h0000;
         deg_cnt_reg <= 16'h0000;
      end else begin
         on_cnt_reg <= on_cnt_next;
         deg_cnt_reg <= deg_cnt_next;
      end
   end

   // One event per persisting open condition
   assign open_evt = armed && open_cmp && (deg_cnt_reg == 16'(DEG_CYC - 1));

   chk_open_gate: assert property (@(posedge ref_clk) disable iff (srst)
      open_evt |-> pwm_on && diag_en && $past(open_cmp))
      else $error("open event outside an enabled on phase");
endmodule // nsfm_open_det
`default_nettype wire

// file: shared/nsfm_cfg.svh
`ifndef NSFM_CFG_SVH
`define NSFM_CFG_SVH
// Register byte offsets
`define NSFM_OFF_CTRL 12'h000
`define NSFM_OFF_BLANK 12'h004
`define NSFM_OFF_FLAGS 12'h008
`define NSFM_OFF_OPEN 12'h00C
`define NSFM_OFF_CHEN 12'h010
`define NSFM_OFF_STAT 12'h014
// Control fields
`define NSFM_CTRL_POWER_ON_CLEAR_BIT 0
`define NSFM_CTRL_CLRFLT 1
`define NSFM_CTRL_TH_LSB 8
// Flag bit positions
`define NSFM_FL_POR 0
`define NSFM_FL_ERR 1
`define NSFM_FL_LOWSUP 2
`define NSFM_FL_SUPUV 3
`define NSFM_FL_REF 4
`define NSFM_FL_PRET 5
`define NSFM_FL_TSD 6
`define NSFM_FL_OUT 7
// Threshold range in volts, 1 V per code
`define NSFM_TH_MIN 6'h04
`define NSFM_TH_MAX 6'h23
`define NSFM_TH_RST 6'h04
`define NSFM_BLANK_RST 4'h0
`define NSFM_CHEN_RST 32'h0000_0000
// Pulsed sink width
`define NSFM_PULSE_US 50
`define NSFM_CLK_MHZ 25
`endif

// file: shared/nsfm_pkg.sv
package nsfm_pkg;
   // Device operating states, one-hot
   typedef enum logic [3:0] {
      NSFM_ST_POR = 4'b0001,
      NSFM_ST_INIT = 4'b0010,
      NSFM_ST_NORMAL = 4'b0100,
      NSFM_ST_SHUT = 4'b1000
   } nsfm_state_t;
endpackage

// file: tb/nsfm_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side: plain bus master, one transfer at a time
module nsfm_mcu_model (
   input wire logic ref_clk,
   output logic [11:0] paddr = 12'h000,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [31:0] pwdata = 32'h0,
   output logic [3:0] pstrb = 4'h0,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [31:0] rd_last; // Data of the last transfer
   logic err_last; // Error answer of the last transfer
   // Setup, then access held until pready; only the bench watchdog ends a wait
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      @(posedge ref_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd_last = prdata;
      err_last = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // nsfm_mcu_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "nsfm_cfg.svh"
// Count, compare, report at once
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %0t: got %0h want %0h", $time, g, e); end end
// Four channels, short blanking and deglitch steps
module tb;
   localparam int PW = `NSFM_PULSE_US * `NSFM_CLK_MHZ; // Pulse length in cycles
   localparam logic [11:0] CTL = `NSFM_OFF_CTRL;
   localparam logic [11:0] FLG = `NSFM_OFF_FLAGS;
   localparam logic [11:0] CHE = `NSFM_OFF_CHEN;
   localparam logic [11:0] OPN = `NSFM_OFF_OPEN;
   int error_cnt = 0;
   int n_compared = 0;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [11:0] paddr;
   logic psel, penable, pwrite, pready, pslverr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic bat_uv_in = 1'b0; // Battery undervoltage comparator
   logic err_n_o; // Pin level when sinking
   logic ldo_uv_in = 1'b0, sup_low_in = 1'b0, sup_uv_fall_in = 1'b0, ref_fault_in = 1'b0;
   logic pre_thermal_in = 1'b0, tsd1_in = 1'b0, tsd2_in = 1'b0, sup_uv_rise_in = 1'b1;
   logic [3:0] chan_open_in = 4'h0, pwm_on = 4'h0, channel_output;
   logic err_n_oe, open_diag_en, sls_diag_en, regulator_off;
   logic [5:0] low_supply_threshold;
   logic [5:0] th_in [4] = '{6'h23, 6'h24, 6'h03, 6'h0A}; // Threshold writes
   logic [5:0] th_exp [4] = '{6'h23, 6'h23, 6'h04, 6'h0A}; // Clamped values
   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;
   nsfm_fault_mgr #(.NCH(4), .BLANK_STEP_CYC(2), .OPEN_DEG_CYC(3)) dut (
      .ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bat_uv_in(bat_uv_in), .ldo_uv_in(ldo_uv_in),
      .sup_low_in(sup_low_in), .sup_uv_fall_in(sup_uv_fall_in),
      .sup_uv_rise_in(sup_uv_rise_in), .ref_fault_in(ref_fault_in),
      .pre_thermal_in(pre_thermal_in), .tsd1_in(tsd1_in), .tsd2_in(tsd2_in),
      .chan_open_in(chan_open_in), .pwm_on(pwm_on), .err_n_o(err_n_o), .err_n_oe(err_n_oe),
      .channel_output(channel_output), .low_supply_threshold(low_supply_threshold),
      .open_diag_en(open_diag_en), .sls_diag_en(sls_diag_en),
      .regulator_off(regulator_off));
   nsfm_mcu_model mcu (
      .ref_clk(ref_clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      mcu.xfer(1'b1, a, d, s);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      mcu.xfer(1'b0, a, 32'h0, 4'h0);
      `CHK(mcu.rd_last, e)
   endtask
   // Fault clear, then the flags register must read zero
   task automatic clr_flt();
      wr(CTL, 32'h2, 4'h1);
      rdc(FLG, 32'h0);
   endtask
   // Sink seen early, still on near the end, gone after the width
   task automatic pulse_chk();
      cyc(10);
      `CHK(err_n_oe, 1'b1)
      cyc(PW - 20);
      `CHK(err_n_oe, 1'b1)
      cyc(40);
      `CHK(err_n_oe, 1'b0)
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Hang guard, well past the three pulses
   initial begin
      cyc(20000);
      error_cnt++;
      results();
   end
   initial begin
      cyc(16);
      srst <= 1'b0;
      cyc(8);
      rdc(FLG, 32'h3);
      `CHK({err_n_o, err_n_oe}, 2'b00)
      wr(CTL, 32'h1, 4'h1);
      rdc(CTL, 32'h0400);
      rdc(FLG, 32'h0);
      foreach (th_in[i]) begin
         wr(CTL, {18'h0, th_in[i], 8'h00}, 4'h2);
         cyc(1);
         `CHK(low_supply_threshold, th_exp[i])
      end
      sup_low_in <= 1'b1;
      pulse_chk();
      `CHK({open_diag_en, sls_diag_en}, 2'b00)
      sup_low_in <= 1'b0;
      cyc(6);
      `CHK({open_diag_en, sls_diag_en}, 2'b11)
      rdc(FLG, 32'h6);
      clr_flt();
      wr(CHE, 32'hF, 4'hF);
      sup_uv_fall_in <= 1'b1;
      sup_uv_rise_in <= 1'b0;
      cyc(6);
      `CHK({err_n_oe, channel_output}, 5'h10)
      sup_uv_fall_in <= 1'b0;
      cyc(6);
      `CHK(channel_output, 4'h0)
      sup_uv_rise_in <= 1'b1;
      cyc(6);
      `CHK({err_n_oe, channel_output}, 5'h0F)
      rdc(FLG, 32'hA);
      clr_flt();
      ref_fault_in <= 1'b1;
      cyc(6);
      `CHK(err_n_oe, 1'b1)
      wr(CHE, 32'h0, 4'hF);
      ref_fault_in <= 1'b0;
      cyc(6);
      `CHK({err_n_oe, channel_output}, 5'h00)
      rdc(FLG, 32'h12);
      clr_flt();
      wr(CHE, 32'hF, 4'hF);
      pre_thermal_in <= 1'b1;
      pulse_chk();
      pre_thermal_in <= 1'b0;
      rdc(FLG, 32'h22);
      clr_flt();
      tsd1_in <= 1'b1;
      cyc(6);
      `CHK({err_n_oe, channel_output}, 5'h10)
      tsd1_in <= 1'b0;
      cyc(6);
      `CHK({err_n_oe, channel_output}, 5'h0F)
      rdc(FLG, 32'h42);
      clr_flt();
      wr(`NSFM_OFF_BLANK, 32'h1, 4'h1);
      chan_open_in <= 4'h2;
      cyc(4);
      pwm_on <= 4'hF;
      cyc(3);
      pwm_on <= 4'h0;
      cyc(4);
      rdc(OPN, 32'h0);
      pwm_on <= 4'hF;
      pulse_chk();
      pwm_on <= 4'h0;
      rdc(OPN, 32'h2);
      rdc(FLG, 32'h82);
      `CHK(channel_output, 4'hF)
      chan_open_in <= 4'h0;
      clr_flt();
      tsd2_in <= 1'b1;
      cyc(6);
      `CHK({regulator_off, err_n_oe, channel_output}, 6'h30)
      tsd2_in <= 1'b0;
      cyc(10);
      `CHK({regulator_off, err_n_oe, low_supply_threshold}, 8'h04)
      rdc(FLG, 32'h3);
      rdc(CHE, 32'h0);
      wr(CTL, 32'h1, 4'h1);
      ldo_uv_in <= 1'b1;
      cyc(6);
      ldo_uv_in <= 1'b0;
      cyc(10);
      rdc(FLG, 32'h3);
      wr(CTL, 32'h1, 4'h1);
      rdc(FLG, 32'h0);
      bat_uv_in <= 1'b1;
      cyc(6);
      bat_uv_in <= 1'b0;
      cyc(10);
      rdc(FLG, 32'h3);
      mcu.xfer(1'b0, 12'h020, 32'h0, 4'h0);
      `CHK({mcu.err_last, mcu.rd_last}, 33'h1_0000_0000)
      results();
   end
endmodule // tb
`default_nettype wire
